/* File: aew_pkg.sv */
`default_nettype none
package aew_pkg;
   // task-file register indices on the link
   localparam logic [3:0] REG_DATA = 4'h0;
   localparam logic [3:0] REG_FEATURE = 4'h1;
   localparam logic [3:0] REG_COUNT = 4'h2;
   localparam logic [3:0] REG_LBA_LOW = 4'h3;
   localparam logic [3:0] REG_LBA_MID = 4'h4;
   localparam logic [3:0] REG_LBA_HIGH = 4'h5;
   localparam logic [3:0] REG_DEVICE = 4'h6;
   localparam logic [3:0] REG_COMMAND = 4'h7;
   localparam logic [3:0] REG_ERROR = 4'h8;
   localparam logic [3:0] REG_CONTROL = 4'h9;
   localparam logic [3:0] REG_ERRLOG = 4'hA;
   // command codes
   localparam logic [7:0] CMD_PIO_WRITE_EXT = 8'h34;
   localparam logic [7:0] CMD_STREAM_DMA_WRITE = 8'h3A;
   // status bit positions
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_STREAM_ERR = 5;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   // error, error-log, feature and control bit positions
   localparam int ER_CRC = 7;
   localparam int ER_NOT_FOUND = 4;
   localparam int ER_ABORTED = 2;
   localparam int ER_TIMEOUT = 0;
   localparam int FEAT_WRITE_CONT = 6;
   localparam int CTL_HIGH_BYTE_SEL = 7;
   localparam int STREAM_ID_LSB = 0;
   // sizes and reset values
   localparam logic [7:0] WORD_LAST = 8'hFF;
   localparam logic [16:0] COUNT_ZERO_SECTORS = 17'h10000;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // time base and host setup step count
   localparam int CLK_PERIOD_NS = 8;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
   localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
   localparam int HOST_STEPS = 11;
   localparam logic [3:0] HOST_STEP_CMD = 4'(HOST_STEPS - 1);
endpackage
`default_nettype wire

/* File: aew_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface aew_if;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic dma_req;
   logic dma_valid;
   logic [15:0] dma_data;
   modport dev (input addr, wdata, wr, rd, dma_valid, dma_data, output rdata, dma_req);
   modport host (output addr, wdata, wr, rd, dma_valid, dma_data, input rdata, dma_req);
endinterface
`default_nettype wire

/* File: aew_device.sv */
// Operation
// - code 34h starts PIO extended sector write
// - PIO data moves as 16-bit data words
// - uncorrectable error ends PIO at failing sector
// - count: low byte current, high previous
// - count zero means 65,536 sectors
// - 48-bit address spread over current/previous bytes
// - first bad address readable, high byte select
// - code 3Ah starts streaming DMA write
// - requested extras done before completion reported
// - write-continuous never aborts on errors
// - write-continuous errors: all data, stream error
// - log records CRC, address-not-found, aborted
// - time limit expiry stops, stream error, timeout (code sets stream error only with write-continuous, else error bit)
// - whole transfer attempted within time limit
// - feature bit 6 selects write-continuous
// - feature bits 0-2 carry stream identifier
// - limit is previous feature times unit microseconds
// - time-limit expiry sets error bit 0
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module aew_device
   import aew_pkg::*;
#(
   parameter logic [15:0] TIME_UNIT_US = 16'h0001
) (
   input wire logic clk_sys_i,           // system clock
   input wire logic rst_b_i,             // async reset, active low
   aew_if.dev tf,                        // task-file and dma link
   input wire logic media_unc_i,         // uncorrectable media fault
   input wire logic media_not_found_i,   // address not found fault
   input wire logic link_crc_i,          // interface crc fault
   output logic media_valid_o,           // word to media
   output logic [15:0] media_data_o,     // media word
   output logic [47:0] media_lba_o,      // sector of the word
   output logic [2:0] media_stream_o,    // stream being written
   output logic busy_o                   // command in progress
);
   typedef enum logic [1:0] {S_IDLE, S_PIO, S_DMA} aew_state_e;
   typedef struct packed {
      aew_state_e st;
      logic [7:0] feat_c;
      logic [7:0] feat_p;
      logic [7:0] cnt_c;
      logic [7:0] cnt_p;
      logic [2:0][7:0] lba_c;
      logic [2:0][7:0] lba_p;
      logic high_byte_readback_select;
      logic err;
      logic stream_error_flag;
      logic write_continuous;
      logic got_err;
      logic [7:0] error;
      logic [7:0] log;
      logic [47:0] err_lba;
      logic [47:0] cur_lba;
      logic [16:0] remain;
      logic [7:0] widx;
      logic [6:0] us_pre;
      logic [23:0] us_cnt;
      logic [23:0] limit;
      logic [15:0] rdata;
      logic dma_req;
      logic media_valid;
      logic [15:0] media_data;
      logic [47:0] media_lba;
      logic [2:0] stream;
      logic busy;
   } aew_dev_s;

   aew_dev_s q, n;

   function automatic logic [7:0] pick(input logic sel, input logic [7:0] lo, input logic [7:0] hi);
      pick = sel ? hi : lo;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic word_in;
   logic [15:0] word;
   logic fault;

   always_comb begin
      n = q;
      n.media_valid = 1'b0;
      word_in = 1'b0;
      word = tf.wdata;
      fault = 1'b0;
      // task-file writes, accepted only while idle
      if (tf.wr && q.st == S_IDLE) begin
         if (tf.addr == REG_FEATURE) begin
            n.feat_p = q.feat_c;
            n.feat_c = tf.wdata[7:0];
         end else if (tf.addr == REG_COUNT) begin
            n.cnt_p = q.cnt_c;
            n.cnt_c = tf.wdata[7:0];
         end else if (tf.addr >= REG_LBA_LOW && tf.addr <= REG_LBA_HIGH) begin
            n.lba_p[2'(tf.addr - REG_LBA_LOW)] = q.lba_c[2'(tf.addr - REG_LBA_LOW)];
            n.lba_c[2'(tf.addr - REG_LBA_LOW)] = tf.wdata[7:0];
         end else if (tf.addr == REG_CONTROL) begin
            n.high_byte_readback_select = tf.wdata[CTL_HIGH_BYTE_SEL];
         end else if (tf.addr == REG_COMMAND) begin
            n.err = 1'b0;
            n.stream_error_flag = 1'b0;
            n.error = RESET_BYTE;
            n.log = RESET_BYTE;
            n.got_err = 1'b0;
            n.remain = {q.cnt_p, q.cnt_c} == 16'h0000 ? COUNT_ZERO_SECTORS : {1'b0, q.cnt_p, q.cnt_c};
            n.cur_lba = {q.lba_p[2], q.lba_p[1], q.lba_p[0], q.lba_c[2], q.lba_c[1], q.lba_c[0]};
            n.widx = 8'h00;
            n.us_pre = 7'h00;
            n.us_cnt = 24'h000000;
            n.limit = 24'(q.feat_p * TIME_UNIT_US);
            n.write_continuous = q.feat_c[FEAT_WRITE_CONT];
            n.stream = q.feat_c[STREAM_ID_LSB +: 3];
            if (tf.wdata[7:0] == CMD_PIO_WRITE_EXT) begin
               n.st = S_PIO;
            end else if (tf.wdata[7:0] == CMD_STREAM_DMA_WRITE) begin
               n.st = S_DMA;
               n.dma_req = 1'b1;
            end else begin
               n.err = 1'b1;
               n.error[ER_ABORTED] = 1'b1;
            end
         end
      end
      // data words: pio through the data register, stream over dma
      if (q.st == S_PIO && tf.wr && tf.addr == REG_DATA) begin
         word_in = 1'b1;
      end else if (q.st == S_DMA && tf.dma_valid) begin
         word_in = 1'b1;
         word = tf.dma_data;
      end
      if (word_in) begin
         n.media_valid = 1'b1;
         n.media_data = word;
         n.media_lba = q.cur_lba;
         n.widx = q.widx + 8'h01;
         if (q.widx == WORD_LAST) begin
            n.cur_lba = q.cur_lba + 48'h1;
            n.remain = q.remain - 17'h1;
            if (q.remain == 17'h1) begin
               n.st = S_IDLE;
               n.dma_req = 1'b0;
               n.stream_error_flag = q.write_continuous
                  && (q.got_err || link_crc_i || media_not_found_i || media_unc_i);
            end
         end
      end
      // faults while a command runs
      if (q.st == S_PIO && (media_unc_i || media_not_found_i)) begin
         n.st = S_IDLE;
         n.err = 1'b1;
         n.error[ER_NOT_FOUND] = media_not_found_i;
         n.error[ER_ABORTED] = media_unc_i;
         n.err_lba = q.cur_lba;
         n.media_valid = 1'b0;
      end else if (q.st == S_DMA && (link_crc_i || media_not_found_i || media_unc_i)) begin
         fault = 1'b1;
         if (!q.got_err) begin
            n.err_lba = q.cur_lba;
         end
         n.got_err = 1'b1;
         if (q.write_continuous) begin
            n.log[ER_CRC] = q.log[ER_CRC] | link_crc_i;
            n.log[ER_NOT_FOUND] = q.log[ER_NOT_FOUND] | media_not_found_i;
            n.log[ER_ABORTED] = q.log[ER_ABORTED] | media_unc_i;
            n.err = 1'b0;
         end else begin
            n.st = S_IDLE;
            n.dma_req = 1'b0;
            n.err = 1'b1;
            n.error[ER_CRC] = link_crc_i;
            n.error[ER_NOT_FOUND] = media_not_found_i;
            n.error[ER_ABORTED] = media_unc_i;
         end
      end
      // completion time limit in microseconds, zero means no limit
      if (q.st == S_DMA) begin
         n.us_pre = q.us_pre == US_LAST ? 7'h00 : q.us_pre + 7'h01;
         if (q.us_pre == US_LAST) begin
            n.us_cnt = q.us_cnt + 24'h000001;
         end
         if (q.limit != 24'h000000 && q.us_cnt >= q.limit && !(fault && !q.write_continuous)) begin
            n.st = S_IDLE;
            n.dma_req = 1'b0;
            n.error[ER_TIMEOUT] = 1'b1;
            n.log[ER_TIMEOUT] = 1'b1;
            n.stream_error_flag = q.write_continuous;
            n.err = !q.write_continuous;
         end
      end
      // read data appears in the cycle after the strobe
      n.rdata = 16'h0000;
      if (tf.rd) begin
         if (tf.addr == REG_COMMAND) begin
            n.rdata[ST_BUSY] = q.st == S_DMA;
            n.rdata[ST_READY] = 1'b1;
            n.rdata[ST_STREAM_ERR] = q.stream_error_flag;
            n.rdata[ST_DRQ] = q.st == S_PIO;
            n.rdata[ST_ERR] = q.err;
         end else if (tf.addr == REG_ERROR) begin
            n.rdata[7:0] = q.error;
         end else if (tf.addr == REG_ERRLOG) begin
            n.rdata[7:0] = q.log;
         end else if (tf.addr == REG_LBA_LOW) begin
            n.rdata[7:0] = pick(q.high_byte_readback_select, q.err_lba[7:0], q.err_lba[31:24]);
         end else if (tf.addr == REG_LBA_MID) begin
            n.rdata[7:0] = pick(q.high_byte_readback_select, q.err_lba[15:8], q.err_lba[39:32]);
         end else if (tf.addr == REG_LBA_HIGH) begin
            n.rdata[7:0] = pick(q.high_byte_readback_select, q.err_lba[23:16], q.err_lba[47:40]);
         end else begin
            n.rdata = 16'h0000;
         end
      end
      n.busy = n.st != S_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tf.rdata = q.rdata;
   assign tf.dma_req = q.dma_req;
   assign media_valid_o = q.media_valid;
   assign media_data_o = q.media_data;
   assign media_lba_o = q.media_lba;
   assign media_stream_o = q.stream;
   assign busy_o = q.busy;
endmodule
`default_nettype wire

/* File: aew_host.sv */
`timescale 1ns/1ps
`default_nettype none
module aew_host
   import aew_pkg::*;
(
   input wire logic clk_sys_i,           // system clock
   input wire logic rst_b_i,             // async reset, active low
   aew_if.host tf,                       // task-file and dma link
   input wire logic start_i,             // start a command, pulse
   input wire logic [7:0] cmd_i,         // command code
   input wire logic [15:0] feat_i,       // feature previous:current
   input wire logic [15:0] count_i,      // sector count
   input wire logic [47:0] lba_i,        // start address
   input wire logic [15:0] wdata_i,      // data word
   input wire logic wvalid_i,            // data word available
   output logic wready_o,                // data word taken, pulse
   output logic done_o,                  // command finished, pulse
   output logic [7:0] status_o,          // final status
   output logic [7:0] error_o            // final error register
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_POLL, H_WAIT, H_ERR, H_ERRW} aew_hstate_e;
   typedef struct packed {
      aew_hstate_e st;
      logic [3:0] step;
      logic [7:0] cmd;
      logic [4:0][7:0] cur;
      logic [4:0][7:0] prev;
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
      logic dma_valid;
      logic [15:0] dma_data;
      logic wready;
      logic done;
      logic [7:0] status;
      logic [7:0] error;
   } aew_host_s;

   aew_host_s q, n;

   always_comb begin
      n = q;
      n.wr = 1'b0;
      n.rd = 1'b0;
      n.wready = 1'b0;
      n.done = 1'b0;
      n.dma_valid = 1'b0;
      // one stream word every other cycle keeps a word from trailing the end
      if (q.cmd == CMD_STREAM_DMA_WRITE && tf.dma_req && wvalid_i && !q.dma_valid && !q.wready) begin
         n.dma_valid = 1'b1;
         n.dma_data = wdata_i;
         n.wready = 1'b1;
      end
      case (q.st)
         H_IDLE: begin
            if (start_i) begin
               n.cmd = cmd_i;
               n.cur = {lba_i[23:16], lba_i[15:8], lba_i[7:0], count_i[7:0], feat_i[7:0]};
               n.prev = {lba_i[47:40], lba_i[39:32], lba_i[31:24], count_i[15:8], feat_i[15:8]};
               n.step = 4'h0;
               n.st = H_SETUP;
            end
         end
         H_SETUP: begin
            n.wr = 1'b1;
            n.step = q.step + 4'h1;
            if (q.step == HOST_STEP_CMD) begin
               n.addr = REG_COMMAND;
               n.wdata = {8'h00, q.cmd};
               n.st = H_POLL;
            end else begin
               n.addr = REG_FEATURE + {1'b0, q.step[3:1]};
               n.wdata = {8'h00, q.step[0] ? q.cur[q.step[3:1]] : q.prev[q.step[3:1]]};
            end
         end
         H_POLL: begin
            n.rd = 1'b1;
            n.addr = REG_COMMAND;
            n.st = H_WAIT;
         end
         H_WAIT: begin
            n.st = H_POLL;
            if (q.rd) begin
               n.st = H_WAIT;                                    // status stands one cycle after the strobe
            end else if (tf.rdata[ST_DRQ] && wvalid_i) begin
               n.wr = 1'b1;
               n.addr = REG_DATA;
               n.wdata = wdata_i;
               n.wready = 1'b1;
            end else if (!tf.rdata[ST_BUSY] && !tf.rdata[ST_DRQ]) begin
               n.status = tf.rdata[7:0];
               n.st = H_ERR;
            end
         end
         H_ERR: begin
            n.rd = 1'b1;
            n.addr = REG_ERROR;
            n.st = H_ERRW;
         end
         H_ERRW: begin
            if (!q.rd) begin
               n.error = tf.rdata[7:0];
               n.done = 1'b1;
               n.cmd = 8'h00;
               n.st = H_IDLE;
            end
         end
         default: begin
            n.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tf.addr = q.addr;
   assign tf.wdata = q.wdata;
   assign tf.wr = q.wr;
   assign tf.rd = q.rd;
   assign tf.dma_valid = q.dma_valid;
   assign tf.dma_data = q.dma_data;
   assign wready_o = q.wready;
   assign done_o = q.done;
   assign status_o = q.status;
   assign error_o = q.error;
endmodule
`default_nettype wire

/* File: aew_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module aew_chk
   import aew_pkg::*;
(
   input wire logic clk_sys_i,       // system clock
   input wire logic rst_b_i,         // async reset, active low
   input wire logic [3:0] addr,      // register index
   input wire logic [15:0] wdata,    // write data
   input wire logic wr,              // write strobe
   input wire logic rd,              // read strobe
   input wire logic [15:0] rdata,    // read data
   input wire logic dma_req,         // stream transfer running
   input wire logic dma_valid,       // stream word strobe
   input wire logic [15:0] dma_data  // stream word
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   ////////////////////////////////////////////////////////////
   a_strobe_excl: assert property (!(wr && rd))
      else $error("write and read strobe in one cycle");
   a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_stream_req: assert property (wr && addr == REG_COMMAND && wdata[7:0] == CMD_STREAM_DMA_WRITE && !dma_req
      |=> dma_req)
      else $error("stream command without transfer request");
   a_pio_noreq: assert property (wr && addr == REG_COMMAND && wdata[7:0] == CMD_PIO_WRITE_EXT && !dma_req
      |=> !dma_req[*2])
      else $error("sector write raised transfer request");
   a_valid_req: assert property (dma_valid |-> $past(dma_req))
      else $error("stream word without request");
   a_valid_gap: assert property (dma_valid |=> !dma_valid)
      else $error("stream words back to back");
   a_cmd_last: assert property (wr && addr == REG_COMMAND |-> $past(wr) && $past(addr) == REG_LBA_HIGH)
      else $error("command not after address writes");
   a_count_pair: assert property (wr && addr == REG_COUNT && !($past(wr) && $past(addr) == REG_COUNT)
      |=> wr && addr == REG_COUNT)
      else $error("count bytes not written as a pair");
   a_ready_bit: assert property (rd && addr == REG_COMMAND |=> rdata[ST_READY])
      else $error("status read without ready");
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import aew_pkg::*;
   logic clk_sys_i, rst_b_i, start_i, wvalid_i, wready_o, done_o;
   logic [7:0] cmd_i, status_o, error_o;
   logic [15:0] feat_i, count_i, wdata_i, media_data_o, w_base;
   logic [47:0] lba_i, media_lba_o, lba_base;
   logic unc_i, nf_i, crc_i, media_valid_o, busy_o, chk_on, active;
   logic [2:0] media_stream_o;
   logic [1:0] flt_sel;
   int err_total, n_tests, n_media, flt_at, cyc;
   aew_if u_aew_if();
   aew_device #(.TIME_UNIT_US(16'h0001)) u_aew_device(.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .tf(u_aew_if),
      .media_unc_i(unc_i), .media_not_found_i(nf_i), .link_crc_i(crc_i), .media_valid_o(media_valid_o),
      .media_data_o(media_data_o), .media_lba_o(media_lba_o), .media_stream_o(media_stream_o), .busy_o(busy_o));
   aew_host u_aew_host(.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .tf(u_aew_if), .start_i(start_i),
      .cmd_i(cmd_i), .feat_i(feat_i), .count_i(count_i), .lba_i(lba_i), .wdata_i(wdata_i), .wvalid_i(wvalid_i),
      .wready_o(wready_o), .done_o(done_o), .status_o(status_o), .error_o(error_o));
   aew_chk u_aew_chk(.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr(u_aew_if.addr), .wdata(u_aew_if.wdata),
      .wr(u_aew_if.wr), .rd(u_aew_if.rd), .rdata(u_aew_if.rdata), .dma_req(u_aew_if.dma_req),
      .dma_valid(u_aew_if.dma_valid), .dma_data(u_aew_if.dma_data));
   ////////////////////////////////////////////////////////////
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   ////////////////////////////////////////////////////////////
   // source data counts up on every word taken by the host
   always @(posedge clk_sys_i) begin
      if (wready_o) begin
         wdata_i <= wdata_i + 16'h0001;
      end
      unc_i <= active && flt_sel == 2'd1 && n_media >= flt_at;
      nf_i <= active && flt_sel == 2'd2 && n_media >= flt_at;
      crc_i <= active && flt_sel == 2'd3 && n_media >= flt_at;
   end
   // media monitor: word order and sector address of each word while chk_on is set
   always @(posedge clk_sys_i) begin
      if (media_valid_o) begin
         if (chk_on) begin
            check("media word", 48'(w_base + 16'(n_media)), 48'(media_data_o));
            check("media sector", lba_base + 48'(n_media / 256), media_lba_o);
         end
         n_media <= n_media + 1;
      end
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic run(input string name, input logic [7:0] cmd, input logic [15:0] feat, input logic [15:0] cnt,
      input logic [1:0] fsel, input int fat, input logic chk);
      @(posedge clk_sys_i);
      n_media <= 0;
      w_base = wdata_i;
      lba_base = lba_i;
      chk_on <= chk;
      flt_sel <= fsel;
      flt_at <= fat;
      active <= 1'b1;
      start_i <= 1'b1;
      cmd_i <= cmd;
      feat_i <= feat;
      count_i <= cnt;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      // a hang is caught by the cycle ceiling above
      do begin
         @(negedge clk_sys_i);
      end while (done_o !== 1'b1);
      active <= 1'b0;
      repeat (4) @(negedge clk_sys_i);
      $display("test %s done", name);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rst_b_i = 1'b0;
      {start_i, wvalid_i, unc_i, nf_i, crc_i, chk_on, active} = '0;
      cmd_i = 8'h00;
      feat_i = 16'h0000;
      count_i = 16'h0000;
      lba_i = 48'h123456789AFF;
      wdata_i = 16'hA000;
      {w_base, lba_base, flt_sel} = '0;
      {err_total, n_tests, n_media, flt_at, cyc} = '0;
      repeat (5) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      wvalid_i <= 1'b1;
      run("pio two sectors", CMD_PIO_WRITE_EXT, 16'h0000, 16'h0002, 2'd0, 0, 1'b1);
      check("status", 8'h40, status_o);
      check("error", 8'h00, error_o);
      check("words", 48'd512, 48'(n_media));
      run("pio uncorrectable", CMD_PIO_WRITE_EXT, 16'h0000, 16'h0002, 2'd1, 300, 1'b0);
      check("status", 8'h41, status_o);
      check("error", 8'h04, error_o);
      check("stopped in sector", 48'd1, 48'(n_media >= 300 && n_media < 512));
      check("error sector", lba_base + 48'h1, u_aew_device.q.err_lba);
      run("pio address fault", CMD_PIO_WRITE_EXT, 16'h0000, 16'h0001, 2'd2, 10, 1'b0);
      check("error", 8'h10, error_o);
      check("error sector", lba_base, u_aew_device.q.err_lba);
      check("busy", 48'd0, 48'(busy_o));
      run("stream plain", CMD_STREAM_DMA_WRITE, 16'h0005, 16'h0001, 2'd0, 0, 1'b1);
      check("status", 8'h40, status_o);
      check("words", 48'd256, 48'(n_media));
      check("stream id", 48'd5, 48'(media_stream_o));
      run("stream continuous crc", CMD_STREAM_DMA_WRITE, 16'h0043, 16'h0001, 2'd3, 20, 1'b1);
      check("status", 8'h60, status_o);
      check("error", 8'h00, error_o);
      check("words", 48'd256, 48'(n_media));
      check("error log", 48'h80, 48'(u_aew_device.q.log));
      run("stream abort crc", CMD_STREAM_DMA_WRITE, 16'h0003, 16'h0001, 2'd3, 20, 1'b1);
      check("status", 8'h41, status_o);
      check("error", 8'h80, error_o);
      check("cut short", 48'd1, 48'(n_media < 256));
      run("stream continuous not found", CMD_STREAM_DMA_WRITE, 16'h0047, 16'h0001, 2'd2, 5, 1'b1);
      check("status", 8'h60, status_o);
      check("words", 48'd256, 48'(n_media));
      check("error log", 48'h10, 48'(u_aew_device.q.log));
      run("stream continuous limit", CMD_STREAM_DMA_WRITE, 16'h0140, 16'h0001, 2'd0, 0, 1'b1);
      check("status", 8'h60, status_o);
      check("error", 8'h01, error_o);
      check("cut short", 48'd1, 48'(n_media > 0 && n_media < 256));
      check("error log", 48'h01, 48'(u_aew_device.q.log));
      run("stream abort limit", CMD_STREAM_DMA_WRITE, 16'h0100, 16'h0001, 2'd0, 0, 1'b1);
      check("status", 8'h41, status_o);
      check("error", 8'h01, error_o);
      run("unknown command", 8'h00, 16'h0000, 16'h0001, 2'd0, 0, 1'b1);
      check("status", 8'h41, status_o);
      check("error", 8'h04, error_o);
      check("words", 48'd0, 48'(n_media));
      stop_test();
   end
endmodule
`default_nettype wire
